// *** cmdstat_map.svh ***
/*
  Offsets, field positions and reset values of the primary command/status word.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CMDSTAT_MAP_SVH
`define CMDSTAT_MAP_SVH

// ----------------------------------------------------------------------
// register offset (command low half, status high half)
// ----------------------------------------------------------------------
`define CS_OFFSET          8'h04
`define CS_CAP_PTR_OFFSET  8'h34

// ----------------------------------------------------------------------
// command bit positions
// ----------------------------------------------------------------------
`define CMD_IO_EN          0
`define CMD_MEM_EN         1
`define CMD_MASTER_EN      2
`define CMD_SPECIAL        3
`define CMD_MWI            4
`define CMD_PALETTE        5
`define CMD_PARITY_RESP    6
`define CMD_WAIT_CYC       7
`define CMD_SYSERR_EN      8
`define CMD_FBB_EN         9
`define CMD_INT_DIS        10

// ----------------------------------------------------------------------
// status bit positions (within the 32-bit word)
// ----------------------------------------------------------------------
`define STS_CAP_LIST       20
`define STS_66MHZ          21
`define STS_FBB_CAP        23
`define STS_MDPE           24

// ----------------------------------------------------------------------
// writable command mask and palette addresses
// ----------------------------------------------------------------------
`define CMD_WR_MASK_FWD    16'h0147
`define CMD_WR_MASK_REV    16'h0567
`define CMD_RESET          16'h0000
`define PAL_ADDR_A         10'h3c6
`define PAL_ADDR_B         10'h3c8
`define PAL_ADDR_C         10'h3c9

`endif

// *** cmdstat_pkg.sv ***
/*
  Types shared by the command/status register bank.
  Assumes cmdstat_map.svh is on the include path.
*/
package cmdstat_pkg;
  typedef enum logic {
    MODE_FORWARD,
    MODE_REVERSE
  } bridge_mode_t;
endpackage : cmdstat_pkg

// *** mdpe_events.sv ***
/*
  Collects the primary-side parity events that set the master data parity flag.
  Assumes event inputs are single-cycle pulses on SYS_CLK; the parity line is a pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmdstat_map.svh"

module mdpe_events (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic reverse_mode,
  input  wire logic parity_resp_en,
  // forward events
  input  wire logic fwd_poisoned_cpl,
  input  wire logic fwd_poisoned_wr,
  // reverse events
  input  wire logic rev_read_perr,
  input  wire logic rev_writing,
  input  wire logic primary_parity_error_n,
  input  wire logic rev_split_wr_perr,
  // result
  output var  logic set_mdpe
);

  typedef struct packed {
    logic [2:0] perr_sync;
    logic [1:0] wr_dly;
    logic       set;
  } ev_state_t;

  ev_state_t st_reg;
  ev_state_t st_next;

  logic perr_seen;

  // ----------------------------------------------------------------------
  // pin synchroniser and event merge
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.perr_sync = {st_reg.perr_sync[1:0], ~primary_parity_error_n};
    // writing delayed so it pairs with the line sample that stage two holds
    st_next.wr_dly    = {st_reg.wr_dly[0], rev_writing};
    // second and third stages agree on an asserted line
    perr_seen = st_reg.perr_sync[1] & st_reg.perr_sync[2];
    if (!reverse_mode) begin
      st_next.set = parity_resp_en & (fwd_poisoned_cpl | fwd_poisoned_wr);
    end else begin
      st_next.set = parity_resp_en &
                    (rev_read_perr | (perr_seen & st_reg.wr_dly[1]) |
                     rev_split_wr_perr);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign set_mdpe = st_reg.set;

  property p_fwd_set;
    @(posedge clk) disable iff (!resetn)
      (!reverse_mode && parity_resp_en && fwd_poisoned_cpl) |=> set_mdpe;
  endproperty
  a_fwd_set: assert property (p_fwd_set) else $error("forward poison did not set flag");

  property p_no_set_gated;
    @(posedge clk) disable iff (!resetn)
      !parity_resp_en |=> !set_mdpe;
  endproperty
  a_no_set_gated: assert property (p_no_set_gated) else $error("flag set while gated");

  property p_rev_set;
    @(posedge clk) disable iff (!resetn)
      (reverse_mode && parity_resp_en && (rev_read_perr || rev_split_wr_perr)) |=> set_mdpe;
  endproperty
  a_rev_set: assert property (p_rev_set) else $error("reverse event missed");

endmodule : mdpe_events
`default_nettype wire

// *** bridge_primary_command_status.sv ***
/*
  Primary command and status word of the bridge configuration header, with
  the decode, master and error gating outputs the command bits steer.
  Assumes config accesses arrive as one-cycle strobes on SYS_CLK with byte
  enables; the mode input is static after reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmdstat_map.svh"

// Overview of operation
// - command bit 0 clear ignores primary I/O other than reverse palette writes; set enables decode response
// - command bit 1 clear ignores primary memory reads; set accepts them
// - bit 2 clear: no primary mastering, no secondary memory/I/O response
// - bit 2 set: master on primary for traffic forwarded from secondary
// - bit 3 read-only zero; special cycles never claimed
// - bit 4 read-only zero; invalidate writes only forwarded
// - reverse with bit 5: claim palette writes at 3C6h, 3C8h, 3C9h low ten bits
// - bit 6 gates the master data parity flag
// - bits 7 and 9 read-only zero
// - reverse with bit 10: legacy interrupt held deasserted
// - status bit 20 reads one: capability list at 34h
// - status bit 21 resets zero forward, one reverse
// - status bit 23 resets zero forward, one reverse on PCI link
// - forward: poisoned completion or poisoned write sets bit 24
// - reverse: three parity events set bit 24
// - write-one-clear flags clear only on a written one
module bridge_primary_command_status (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  // orientation
  input  wire logic        REVERSE_MODE,
  input  wire logic        LINK_IS_PCI,
  // configuration access
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  output var  logic [31:0] CFG_RDATA,
  output var  logic        CFG_RVALID,
  // primary transaction decode
  input  wire logic        PRI_IO_REQ,
  input  wire logic        PRI_IO_WRITE,
  input  wire logic [15:0] PRI_IO_ADDR,
  input  wire logic        PRI_MEM_RD_REQ,
  output var  logic        PRI_IO_CLAIM,
  output var  logic        PRI_MEM_RD_CLAIM,
  output var  logic        PRI_PALETTE_CLAIM,
  // forwarding
  input  wire logic        SEC_FWD_REQ,
  output var  logic        SEC_RESPOND,
  output var  logic        PRI_MASTER_GO,
  // parity events
  input  wire logic        FWD_POISONED_CPL,
  input  wire logic        FWD_POISONED_WR,
  input  wire logic        REV_READ_PERR,
  input  wire logic        REV_WRITING,
  input  wire logic        PRIMARY_PARITY_ERROR_N,
  input  wire logic        REV_SPLIT_WR_PERR,
  // error and interrupt
  input  wire logic        ERR_EVENT,
  input  wire logic        INT_REQ,
  output var  logic        ERR_MSG_SEND,
  output var  logic        SYSTEM_ERROR_OUT_N,
  output var  logic        LEGACY_INTERRUPT_OUT_N
);

  typedef struct packed {
    logic [15:0] cmd;
    logic        mdpe;
    logic        cap66;
    logic        fbb_cap;
    logic        init_done;
    logic [31:0] rdata;
    logic        rvalid;
    logic        io_claim;
    logic        mem_claim;
    logic        pal_claim;
    logic        sec_resp;
    logic        master_go;
    logic        err_msg;
    logic        serr_n;
    logic        int_n;
  } cs_state_t;

  cs_state_t st_reg;
  cs_state_t st_next;

  logic               set_mdpe;
  logic [15:0]        wr_mask;
  logic [15:0]        be_mask;
  logic               hit;
  cmdstat_pkg::bridge_mode_t mode;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic pal_match(input logic [15:0] a);
    logic [9:0] lo;
    lo = a[9:0]; // upper bits ignored so ISA aliases match
    return (lo == `PAL_ADDR_A) || (lo == `PAL_ADDR_B) || (lo == `PAL_ADDR_C);
  endfunction : pal_match

  function automatic logic [31:0] status_word(input cs_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[15:0]          = s.cmd;
    w[`STS_CAP_LIST] = 1'b1;
    w[`STS_66MHZ]    = s.cap66;
    w[`STS_FBB_CAP]  = s.fbb_cap;
    w[`STS_MDPE]     = s.mdpe;
    return w;
  endfunction : status_word

  mdpe_events u_mdpe (
    .clk                    (SYS_CLK),
    .resetn                 (RESETN),
    .reverse_mode           (REVERSE_MODE),
    .parity_resp_en         (st_reg.cmd[`CMD_PARITY_RESP]),
    .fwd_poisoned_cpl       (FWD_POISONED_CPL),
    .fwd_poisoned_wr        (FWD_POISONED_WR),
    .rev_read_perr          (REV_READ_PERR),
    .rev_writing            (REV_WRITING),
    .primary_parity_error_n (PRIMARY_PARITY_ERROR_N),
    .rev_split_wr_perr      (REV_SPLIT_WR_PERR),
    .set_mdpe               (set_mdpe)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    mode    = REVERSE_MODE ? cmdstat_pkg::MODE_REVERSE : cmdstat_pkg::MODE_FORWARD;
    hit     = (CFG_ADDR == `CS_OFFSET);
    be_mask = {{8{CFG_BE[1]}}, {8{CFG_BE[0]}}};
    case (mode)
      cmdstat_pkg::MODE_FORWARD: wr_mask = `CMD_WR_MASK_FWD;
      cmdstat_pkg::MODE_REVERSE: wr_mask = `CMD_WR_MASK_REV;
      default:                   wr_mask = `CMD_WR_MASK_FWD;
    endcase

    // strap-like reset values taken on the first clock after release
    if (!st_reg.init_done) begin
      st_next.init_done = 1'b1;
      st_next.cap66     = REVERSE_MODE;
      st_next.fbb_cap   = REVERSE_MODE & LINK_IS_PCI;
    end

    // bits 3,4,7,9 and 11..15 never in the mask, so they stay zero
    if (CFG_WR && hit) begin
      st_next.cmd = (st_reg.cmd & ~(wr_mask & be_mask)) |
                    (CFG_WDATA[15:0] & wr_mask & be_mask);
    end

    // set wins over a simultaneous write-one clear
    if (CFG_WR && hit && CFG_BE[3] && CFG_WDATA[`STS_MDPE]) begin
      st_next.mdpe = 1'b0;
    end
    if (set_mdpe) begin
      st_next.mdpe = 1'b1;
    end

    st_next.rvalid = CFG_RD;
    st_next.rdata  = (CFG_RD && hit) ? status_word(st_reg) : 32'h0000_0000;

    // decode and gating outputs
    st_next.io_claim  = PRI_IO_REQ & st_reg.cmd[`CMD_IO_EN];
    st_next.mem_claim = PRI_MEM_RD_REQ & st_reg.cmd[`CMD_MEM_EN];
    st_next.pal_claim = REVERSE_MODE & st_reg.cmd[`CMD_PALETTE] &
                        PRI_IO_REQ & PRI_IO_WRITE & pal_match(PRI_IO_ADDR);
    st_next.sec_resp  = SEC_FWD_REQ & st_reg.cmd[`CMD_MASTER_EN];
    st_next.master_go = SEC_FWD_REQ & st_reg.cmd[`CMD_MASTER_EN];
    st_next.err_msg   = ERR_EVENT & st_reg.cmd[`CMD_SYSERR_EN] & !REVERSE_MODE;
    st_next.serr_n    = ~(ERR_EVENT & st_reg.cmd[`CMD_SYSERR_EN] & REVERSE_MODE);
    st_next.int_n     = ~(INT_REQ & ~(REVERSE_MODE & st_reg.cmd[`CMD_INT_DIS]));
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESETN) begin
      st_reg        <= '0;
      st_reg.serr_n <= 1'b1;
      st_reg.int_n  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign CFG_RDATA              = st_reg.rdata;
  assign CFG_RVALID             = st_reg.rvalid;
  assign PRI_IO_CLAIM           = st_reg.io_claim;
  assign PRI_MEM_RD_CLAIM       = st_reg.mem_claim;
  assign PRI_PALETTE_CLAIM      = st_reg.pal_claim;
  assign SEC_RESPOND            = st_reg.sec_resp;
  assign PRI_MASTER_GO          = st_reg.master_go;
  assign ERR_MSG_SEND           = st_reg.err_msg;
  assign SYSTEM_ERROR_OUT_N     = st_reg.serr_n;
  assign LEGACY_INTERRUPT_OUT_N = st_reg.int_n;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_io_gate;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (PRI_IO_REQ && !st_reg.cmd[`CMD_IO_EN]) |=> !PRI_IO_CLAIM;
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("io claimed while disabled");

  property p_mem_gate;
    @(posedge SYS_CLK) disable iff (!RESETN)
      PRI_MEM_RD_REQ |=> (PRI_MEM_RD_CLAIM == $past(st_reg.cmd[`CMD_MEM_EN]));
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("mem read claim wrong");

  property p_master_gate;
    @(posedge SYS_CLK) disable iff (!RESETN)
      !st_reg.cmd[`CMD_MASTER_EN] |=> !PRI_MASTER_GO && !SEC_RESPOND;
  endproperty
  a_master_gate: assert property (p_master_gate) else $error("master while disabled");

  property p_master_go;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (SEC_FWD_REQ && st_reg.cmd[`CMD_MASTER_EN]) |=> PRI_MASTER_GO;
  endproperty
  a_master_go: assert property (p_master_go) else $error("forward not mastered");

  property p_ro_zero;
    @(posedge SYS_CLK) disable iff (!RESETN)
      st_reg.cmd[15:11] == 5'h00 && !st_reg.cmd[3] && !st_reg.cmd[4] &&
      !st_reg.cmd[7] && !st_reg.cmd[9];
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("read-only bit set");

  property p_palette;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (!REVERSE_MODE) |=> !PRI_PALETTE_CLAIM;
  endproperty
  a_palette: assert property (p_palette) else $error("palette claimed forward");

  property p_serr;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (ERR_EVENT && REVERSE_MODE && st_reg.cmd[`CMD_SYSERR_EN]) |=> !SYSTEM_ERROR_OUT_N;
  endproperty
  a_serr: assert property (p_serr) else $error("system error not asserted");

  property p_intdis;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (REVERSE_MODE && st_reg.cmd[`CMD_INT_DIS]) |=> LEGACY_INTERRUPT_OUT_N;
  endproperty
  a_intdis: assert property (p_intdis) else $error("interrupt not masked");

  property p_w1c;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (st_reg.mdpe && !(CFG_WR && hit && CFG_BE[3] && CFG_WDATA[`STS_MDPE])) |=> st_reg.mdpe;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag lost without clear");

  property p_cap;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (CFG_RD && hit) |=> CFG_RVALID && CFG_RDATA[`STS_CAP_LIST];
  endproperty
  a_cap: assert property (p_cap) else $error("capability bit not read as one");

  property p_err_fwd;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (ERR_EVENT && !REVERSE_MODE && st_reg.cmd[`CMD_SYSERR_EN]) |=>
        ERR_MSG_SEND && SYSTEM_ERROR_OUT_N;
  endproperty
  a_err_fwd: assert property (p_err_fwd) else $error("error message not sent");

  property p_set_wins;
    @(posedge SYS_CLK) disable iff (!RESETN)
      set_mdpe |=> st_reg.mdpe;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("parity flag not set");

  property p_straps;
    @(posedge SYS_CLK) disable iff (!RESETN)
      $rose(st_reg.init_done) |->
        (st_reg.cap66 == $past(REVERSE_MODE)) &&
        (st_reg.fbb_cap == $past(REVERSE_MODE && LINK_IS_PCI));
  endproperty
  a_straps: assert property (p_straps) else $error("strap value wrong");

  property p_straps_hold;
    @(posedge SYS_CLK) disable iff (!RESETN)
      st_reg.init_done |=> $stable(st_reg.cap66) && $stable(st_reg.fbb_cap);
  endproperty
  a_straps_hold: assert property (p_straps_hold) else $error("strap changed");

  property p_pal_claim;
    @(posedge SYS_CLK) disable iff (!RESETN)
      (REVERSE_MODE && st_reg.cmd[`CMD_PALETTE] && PRI_IO_REQ && PRI_IO_WRITE &&
       (PRI_IO_ADDR[9:0] == `PAL_ADDR_A || PRI_IO_ADDR[9:0] == `PAL_ADDR_B ||
        PRI_IO_ADDR[9:0] == `PAL_ADDR_C)) |=> PRI_PALETTE_CLAIM;
  endproperty
  a_pal_claim: assert property (p_pal_claim) else $error("palette not claimed");

  property p_reset_outs;
    @(posedge SYS_CLK)
      !RESETN |=> SYSTEM_ERROR_OUT_N && LEGACY_INTERRUPT_OUT_N && !CFG_RVALID &&
                  (st_reg.cmd == 16'h0000) && !st_reg.mdpe;
  endproperty
  a_reset_outs: assert property (p_reset_outs) else $error("reset state wrong");

endmodule : bridge_primary_command_status
`default_nettype wire

// *** cfg_host.sv ***
/*
  Host model that issues configuration strobes to the command/status bank.
  Assumes one free-running clock and an answer one cycle after a read strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module cfg_host (
  // clock
  input  wire logic        clk,
  // configuration access
  output var  logic        cfg_wr,
  output var  logic        cfg_rd,
  output var  logic [7:0]  cfg_addr,
  output var  logic [3:0]  cfg_be,
  output var  logic [31:0] cfg_wdata,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rvalid
);
  initial begin
    cfg_wr    = 1'b0;
    cfg_rd    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // ----------------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------------
  // released lines show the inverse so a stale value never looks valid
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr    <= 1'b0;
    cfg_addr  <= ~a;
    cfg_be    <= ~be;
    cfg_wdata <= ~d;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d  = 32'h0000_0000;
    @(posedge clk);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd   <= 1'b0;
    cfg_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (cfg_rvalid === 1'b1) begin
        d  = cfg_rdata;
        ok = 1'b1;
      end
    end
  endtask : rd
endmodule : cfg_host

`default_nettype wire

// *** bridge_primary_command_status_test.sv ***
/*
  Self-checking bench for the primary command/status bank, both orientations.
  Assumes cfg_host.sv and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module bridge_primary_command_status_test;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        rev = 1'b0;
  logic        pci = 1'b1;
  logic        io_wr = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic        writing = 1'b0;
  logic        perr_n = 1'b1;
  logic        int_req = 1'b0;
  logic [7:0]  ev = 8'h00;
  wire  [7:0]  obs;
  logic        cwr, crd, cvalid;
  logic [7:0]  caddr;
  logic [3:0]  cbe;
  logic [31:0] cwd, crdat;
  int          n_mismatch = 0;
  int          checks_done = 0;
  logic [7:0]  ev_tab [4] = '{8'h01, 8'h02, 8'h04, 8'h80};
  logic [7:0]  on_tab [4] = '{8'hc1, 8'hc2, 8'hd8, 8'he0};
  logic [15:0] pal_tab [4] = '{16'hf3c6, 16'h03c8, 16'ha3c9, 16'h03c7};
  logic [7:0]  pal_exp [4] = '{8'hc5, 8'hc5, 8'hc5, 8'hc1};

  always #5 sys_clk = ~sys_clk;

  cfg_host u_cfg_host (.clk(sys_clk), .cfg_wr(cwr), .cfg_rd(crd), .cfg_addr(caddr),
    .cfg_be(cbe), .cfg_wdata(cwd), .cfg_rdata(crdat), .cfg_rvalid(cvalid));

  bridge_primary_command_status u_bridge_primary_command_status (
    .SYS_CLK(sys_clk), .RESETN(resetn), .REVERSE_MODE(rev), .LINK_IS_PCI(pci),
    .CFG_WR(cwr), .CFG_RD(crd), .CFG_ADDR(caddr), .CFG_BE(cbe), .CFG_WDATA(cwd),
    .CFG_RDATA(crdat), .CFG_RVALID(cvalid),
    .PRI_IO_REQ(ev[0]), .PRI_IO_WRITE(io_wr), .PRI_IO_ADDR(io_addr),
    .PRI_MEM_RD_REQ(ev[1]), .PRI_IO_CLAIM(obs[0]), .PRI_MEM_RD_CLAIM(obs[1]),
    .PRI_PALETTE_CLAIM(obs[2]), .SEC_FWD_REQ(ev[2]), .SEC_RESPOND(obs[3]),
    .PRI_MASTER_GO(obs[4]), .FWD_POISONED_CPL(ev[3]), .FWD_POISONED_WR(ev[4]),
    .REV_READ_PERR(ev[5]), .REV_WRITING(writing), .PRIMARY_PARITY_ERROR_N(perr_n),
    .REV_SPLIT_WR_PERR(ev[6]), .ERR_EVENT(ev[7]), .INT_REQ(int_req),
    .ERR_MSG_SEND(obs[5]), .SYSTEM_ERROR_OUT_N(obs[6]), .LEGACY_INTERRUPT_OUT_N(obs[7]));

  // ----------------------------------------------------------------------
  // compare and access helpers
  // ----------------------------------------------------------------------
  task end_of_test;
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    u_cfg_host.rd(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      end_of_test();
    end else begin
      chk32(d, exp);
    end
  endtask : rd_chk

  // one request pulse, outputs judged the cycle after it is taken
  task fire(input logic [7:0] v, input logic [7:0] exp);
    @(posedge sys_clk);
    ev <= v;
    @(posedge sys_clk);
    ev <= 8'h00;
    @(posedge sys_clk);
    chk8(obs, exp);
  endtask : fire

  task do_reset(input logic mode);
    @(posedge sys_clk);
    rev    <= mode;
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : do_reset

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset(1'b0);
    chk8(obs, 8'hc0);
    rd_chk(8'h04, 32'h0010_0000);
    u_cfg_host.wr(8'h04, 4'hf, 32'hffff_ffff);
    rd_chk(8'h04, 32'h0010_0147);
    rd_chk(8'h08, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
      fire(ev_tab[i], on_tab[i]);
    u_cfg_host.wr(8'h04, 4'h1, 32'h0000_0000);
    rd_chk(8'h04, 32'h0010_0100);
    u_cfg_host.wr(8'h04, 4'h3, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
      fire(ev_tab[i], 8'hc0);
    // forward parity flag, then write-zero and write-one clearing
    u_cfg_host.wr(8'h04, 4'h1, 32'h0000_0040);
    fire(8'h08, 8'hc0);
    rd_chk(8'h04, 32'h0110_0040);
    u_cfg_host.wr(8'h04, 4'h8, 32'h0000_0000);
    rd_chk(8'h04, 32'h0110_0040);
    u_cfg_host.wr(8'h04, 4'h8, 32'h0100_0000);
    rd_chk(8'h04, 32'h0010_0040);
    fire(8'h10, 8'hc0);
    rd_chk(8'h04, 32'h0110_0040);
    u_cfg_host.wr(8'h04, 4'h9, 32'h0100_0000);
    fire(8'h18, 8'hc0);
    rd_chk(8'h04, 32'h0010_0000);
    // reverse orientation
    do_reset(1'b1);
    rd_chk(8'h04, 32'h00b0_0000);
    u_cfg_host.wr(8'h04, 4'hf, 32'hffff_ffff);
    rd_chk(8'h04, 32'h00b0_0567);
    fire(8'h80, 8'h80);
    io_wr <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      io_addr <= pal_tab[i];
      fire(8'h01, pal_exp[i]);
    end
    fire(8'h20, 8'hc0);
    rd_chk(8'h04, 32'h01b0_0567);
    u_cfg_host.wr(8'h04, 4'h8, 32'h0100_0000);
    fire(8'h40, 8'hc0);
    rd_chk(8'h04, 32'h01b0_0567);
    u_cfg_host.wr(8'h04, 4'h8, 32'h0100_0000);
    rd_chk(8'h04, 32'h00b0_0567);
    // synchronised pin needs extra cycles before the flag lands
    @(posedge sys_clk);
    writing <= 1'b1;
    perr_n  <= 1'b0;
    repeat (3) @(posedge sys_clk);
    writing <= 1'b0;
    perr_n  <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rd_chk(8'h04, 32'h01b0_0567);
    int_req <= 1'b1;
    fire(8'h00, 8'hc0);
    u_cfg_host.wr(8'h04, 4'h2, 32'h0000_0000);
    fire(8'h00, 8'h40);
    // reverse on a non-PCI link: fast back-to-back capability stays clear
    pci <= 1'b0;
    do_reset(1'b1);
    rd_chk(8'h04, 32'h0030_0000);
    end_of_test();
  end
endmodule : bridge_primary_command_status_test

`default_nettype wire
